// ===== core/psfc_consts.svh
// timing counts and fixed figures for the power supervisor fault control block
`ifndef PSFC_CONSTS_SVH
`define PSFC_CONSTS_SVH

`define PSFC_CLK_MHZ        200
`define PSFC_CNT_W          22
`define PSFC_UV_TIME_US     32
`define PSFC_UV_CYC         (`PSFC_UV_TIME_US * `PSFC_CLK_MHZ)
`define PSFC_RES_TIME_US    5
`define PSFC_RES_CYC        (`PSFC_RES_TIME_US * `PSFC_CLK_MHZ)
`define PSFC_PG_TIME_MS     10
`define PSFC_PG_CYC         (`PSFC_PG_TIME_MS * 1000 * `PSFC_CLK_MHZ)
`define PSFC_ERR_TIME_US    200
`define PSFC_ERR_CYC        (`PSFC_ERR_TIME_US * `PSFC_CLK_MHZ)
`define PSFC_KICK_TIME_US   50
`define PSFC_KICK_CYC       (`PSFC_KICK_TIME_US * `PSFC_CLK_MHZ)
`define PSFC_WD_EARLY_US    1000
`define PSFC_WD_EARLY_CYC   (`PSFC_WD_EARLY_US * `PSFC_CLK_MHZ)
`define PSFC_WD_LATE_US     10000
`define PSFC_WD_LATE_CYC    (`PSFC_WD_LATE_US * `PSFC_CLK_MHZ)
`define PSFC_SW_KHZ_X10     21
`define PSFC_SW_NOM_CYC     ((`PSFC_CLK_MHZ * 10) / `PSFC_SW_KHZ_X10)
`define PSFC_DITHER_PCT     6
`define PSFC_SW_MIN_CYC     ((`PSFC_SW_NOM_CYC * 100 + 99 + `PSFC_DITHER_PCT) / (100 + `PSFC_DITHER_PCT))
`define PSFC_THIRD_MUL      85
`define PSFC_LFSR_SEED      8'h01
`define PSFC_USED_MASK_RST  5'h1F

`endif

// ===== core/psfc_pkg.sv
// types shared by the power supervisor fault control block
`include "psfc_consts.svh"
package psfc_pkg;
  typedef enum logic [2:0] {
    ST_REG_OFF,
    ST_SENSE,
    ST_POWER_ON,
    ST_PG_DELAY,
    ST_ACTIVE
  } psfc_state_e;
  typedef logic [`PSFC_CNT_W-1:0] psfc_cnt_t;
endpackage

// ===== core/psfc_top.sv
// supervisor logic: supply qualification, supply and thermal shutdown, phasing, dither, watchdog
`timescale 1ns/1ps
`include "psfc_consts.svh"

// qualification filter: done once cond has held more than n cycles in a row
module psfc_filter #(
  parameter int unsigned N = 16
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic cond_in,
  output logic      done_out
);
  import psfc_pkg::*;
  psfc_cnt_t cnt;       // consecutive cycles with cond high
  psfc_cnt_t next_cnt;  // next count

  // count restarts whenever the condition drops before completion
  always_comb begin
    if (!cond_in) begin
      next_cnt = '0;
    end else if (cnt == `PSFC_CNT_W'(N)) begin
      next_cnt = cnt; // saturate so done stays up
    end else begin
      next_cnt = cnt + `PSFC_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // n+1 cycles held, so strictly longer than n
  assign done_out = cond_in && (cnt == `PSFC_CNT_W'(N));
endmodule

// Behaviour
// - disable all channels after 32 us lockout
// - reinitialise sequencer, overvoltage latch and channel mask after rising threshold
// - overvoltage kills outputs, both indicators low
// - overvoltage restart after 5 us below resume
// - temperature warning pulls fault low, outputs run
// - thermal shutdown kills outputs, power good low
// - restart when thermal comparator deasserts
// - high side on each cycle until peak
// - dither period between nominal and six percent
// - converter phases spread by enabled count
// - sense floating channels during power on
// - mask faults of unused channels
// - release power good 10 ms after ready
// - power good open drain, low or released
// - kick from pin or serial bus
// - window or simple timeout watchdog mode
// - watchdog error low for 200 us
// - kick monitored after power good, pin kick deglitched
module psfc_top #(
  parameter int unsigned UV_CYC      = `PSFC_UV_CYC,
  parameter int unsigned PG_CYC      = `PSFC_PG_CYC,
  parameter int unsigned ERR_CYC     = `PSFC_ERR_CYC,
  parameter int unsigned KICK_CYC    = `PSFC_KICK_CYC,
  parameter int unsigned WD_EARLY_CYC = `PSFC_WD_EARLY_CYC,
  parameter int unsigned WD_LATE_CYC = `PSFC_WD_LATE_CYC
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                supply_low_in,
  input  wire logic                supply_ok_in,
  input  wire logic                supply_ov_in,
  input  wire logic                supply_resume_in,
  input  wire logic                overtemp_warning_in,
  input  wire logic                thermal_shutdown_in,
  input  wire logic                seq_enable_in,
  input  wire logic [2:0]          conv_enable_in,
  input  wire logic                dither_enable_in,
  input  wire logic [2:0]          peak_trip_in,
  input  wire logic [4:0]          ch_ready_in,
  input  wire logic [4:0]          ch_fault_in,
  input  wire logic                ch2_float_in,
  input  wire logic                ch3_float_in,
  input  wire logic                window_watchdog_mode_in,
  input  wire logic                watchdog_kick_input_in,
  input  wire logic                bus_kick_in,
  input  wire logic                power_good_in,
  output logic [4:0]               reg_enable_out,
  output logic [2:0]               hs_switch_out,
  output logic                     power_good_output_out,
  output logic                     power_good_oe_out,
  output logic                     fault_indicator_output_n_out,
  output logic                     watchdog_error_output_n_out,
  output psfc_pkg::psfc_state_e    state_out
);
  import psfc_pkg::*;

  localparam logic [6:0] SW_NOM  = 7'(`PSFC_SW_NOM_CYC);                   // nominal period
  localparam logic [2:0] SW_SPAN = 3'(`PSFC_SW_NOM_CYC - `PSFC_SW_MIN_CYC); // dither reach

  // qualified supply and kick events
  logic uv_done;       // low supply held past lockout filter
  logic resume_done;   // below resume level held long enough
  logic kick_done;     // kick pin level change survived deglitch

  // supervisor state
  logic        lockout, next_lockout;       // undervoltage lockout holds sequencer, latch and mask at default
  logic        ovp_hold, next_ovp_hold;     // latched supply overvoltage
  psfc_state_e state, next_state;           // sequencer state
  psfc_cnt_t   pg_cnt, next_pg_cnt;         // power good delay count
  logic [4:0]  used, next_used;             // populated channel mask
  logic [4:0]  next_reg_en;                 // next regulator enables
  logic        next_fault_n;                // next fault indicator level
  logic        pg_release, next_pg_release; // power good released
  logic        shutdown;                    // any hard shutdown cause
  logic [4:0]  masked_fault;                // faults of populated channels only
  logic [4:0]  ready_eff;                   // readiness with unused channels ignored

  // switching clock state
  logic [6:0] sw_cnt, next_sw_cnt;          // position in switching cycle
  logic [6:0] sw_period, next_sw_period;    // current cycle length
  logic [7:0] lfsr, next_lfsr;              // pseudo-random source
  logic [2:0] dith;                         // cycles to shave from the next period
  logic [2:0] hs, next_hs;                  // high-side switch states
  logic [2:0] sw_start;                     // per converter cycle start
  logic [1:0] n_en;                         // enabled converter count
  logic [13:0] third_prod;                  // period times one third scale
  logic [6:0] third;                        // one third of period

  // watchdog state
  logic       wd_run;                       // watchdog allowed to watch
  logic       kick_lvl, next_kick_lvl;      // deglitched kick pin level
  logic       kick;                         // accepted kick this cycle
  logic       wd_fault;                     // watchdog violation this cycle
  psfc_cnt_t  wd_cnt, next_wd_cnt;          // cycles since last kick
  psfc_cnt_t  err_cnt, next_err_cnt;        // error pulse remaining

  psfc_filter #(.N(UV_CYC)) u_uv_filt (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .cond_in  (supply_low_in),
    .done_out (uv_done)
  );

  psfc_filter #(.N(`PSFC_RES_CYC)) u_res_filt (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .cond_in  (supply_resume_in && ovp_hold),
    .done_out (resume_done)
  );

  psfc_filter #(.N(KICK_CYC)) u_kick_filt (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .cond_in  (wd_run && (watchdog_kick_input_in != kick_lvl)),
    .done_out (kick_done)
  );

  // fault causes and masks
  always_comb begin
    shutdown     = lockout || uv_done || supply_ov_in || ovp_hold || thermal_shutdown_in;
    masked_fault = ch_fault_in & used;
    ready_eff    = ch_ready_in | ~used;
  end

  // lockout, overvoltage latch and sequencer next state
  always_comb begin
    next_lockout    = lockout;
    next_ovp_hold   = ovp_hold;
    next_state      = state;
    next_pg_cnt     = '0;
    next_used       = used;
    // lockout set wins over release
    if (uv_done) begin
      next_lockout = 1'b1;
    end else if (lockout && supply_ok_in) begin
      next_lockout = 1'b0;
    end
    if (supply_ov_in) begin
      next_ovp_hold = 1'b1;
    end else if (resume_done) begin
      next_ovp_hold = 1'b0;
    end
    if (shutdown) begin
      // thermal comparator has its own hysteresis; leaving it releases us
      next_state = ST_REG_OFF;
    end else begin
      unique case (state)
        ST_REG_OFF: begin
          if (seq_enable_in) begin
            next_state = ST_SENSE;
          end
        end
        ST_SENSE: begin
          // floating pins mean nothing fitted on that channel
          // bit 1 is the second converter, bit 2 the third; the rest are always fitted
          next_used  = {2'b11, ~ch3_float_in, ~ch2_float_in, 1'b1};
          next_state = ST_POWER_ON;
        end
        ST_POWER_ON: begin
          if (!seq_enable_in) begin
            next_state = ST_REG_OFF;
          end else if (&ready_eff) begin
            next_state = ST_PG_DELAY;
          end
        end
        ST_PG_DELAY: begin
          next_pg_cnt = pg_cnt + `PSFC_CNT_W'(1);
          if (!seq_enable_in) begin
            next_state = ST_REG_OFF;
          end else if (pg_cnt == `PSFC_CNT_W'(PG_CYC - 1)) begin
            next_state = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (!seq_enable_in) begin
            next_state = ST_REG_OFF;
          end
        end
        default: next_state = ST_REG_OFF;
      endcase
    end
    // lockout forces the overvoltage latch, sequencer state and channel mask back to default
    if (lockout) begin
      next_ovp_hold = 1'b0;
      next_state    = ST_REG_OFF;
      next_used     = `PSFC_USED_MASK_RST;
    end
  end

  // outputs derived from the next state so shutdown acts on the next edge
  always_comb begin
    next_reg_en     = '0;
    next_pg_release = (next_state == ST_ACTIVE);
    if (!shutdown && (next_state == ST_POWER_ON || next_state == ST_PG_DELAY
                      || next_state == ST_ACTIVE)) begin
      next_reg_en = next_used & {2'b11, conv_enable_in};
    end
    // warning keeps outputs running, only the indicator drops
    next_fault_n = !(shutdown || next_state == ST_REG_OFF || overtemp_warning_in
                     || (|masked_fault));
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lockout                      <= 1'b0;
      ovp_hold                     <= 1'b0;
      state                        <= ST_REG_OFF;
      pg_cnt                       <= '0;
      used                         <= `PSFC_USED_MASK_RST;
      reg_enable_out               <= '0;
      pg_release                   <= 1'b0;
      fault_indicator_output_n_out <= 1'b0;
    end else begin
      lockout                      <= next_lockout;
      ovp_hold                     <= next_ovp_hold;
      state                        <= next_state;
      pg_cnt                       <= next_pg_cnt;
      used                         <= next_used;
      reg_enable_out               <= next_reg_en;
      pg_release                   <= next_pg_release;
      fault_indicator_output_n_out <= next_fault_n;
    end
  end

  // open drain: never drive high, only pull low or let go
  assign power_good_output_out = 1'b0;
  assign power_good_oe_out     = !pg_release;
  assign state_out             = state;

  // switching clock, dither and phase placement
  always_comb begin
    dith = (lfsr[2:0] > SW_SPAN) ? lfsr[2:0] - SW_SPAN : lfsr[2:0];
    next_sw_cnt    = sw_cnt + 7'd1;
    next_sw_period = sw_period;
    next_lfsr      = lfsr;
    if (sw_cnt >= sw_period - 7'd1) begin
      next_sw_cnt = '0;
      next_lfsr   = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      // only ever shorten the period, so frequency never drops below nominal
      next_sw_period = dither_enable_in ? SW_NOM - {4'd0, dith} : SW_NOM;
    end
    n_en       = 2'(reg_enable_out[0]) + 2'(reg_enable_out[1]) + 2'(reg_enable_out[2]);
    third_prod = 14'(sw_period * 7'(`PSFC_THIRD_MUL));
    third      = third_prod[13:7] >> 1;
    // slot of each converter is the number of enabled ones below it
    sw_start[0] = reg_enable_out[0] && (sw_cnt == 7'd0);
    sw_start[1] = reg_enable_out[1] && (sw_cnt == (reg_enable_out[0] ?
                  ((n_en == 2'd2) ? (sw_period >> 1) : third) : 7'd0));
    sw_start[2] = reg_enable_out[2] && (sw_cnt ==
                  ((reg_enable_out[0] && reg_enable_out[1]) ? 7'(third << 1) :
                   (reg_enable_out[0] || reg_enable_out[1]) ? (sw_period >> 1) : 7'd0));
    for (int k = 0; k < 3; k++) begin
      if (sw_start[k]) begin
        next_hs[k] = 1'b1;
      end else if (peak_trip_in[k] || !reg_enable_out[k]) begin
        next_hs[k] = 1'b0;
      end else begin
        next_hs[k] = hs[k];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_cnt    <= '0;
      sw_period <= SW_NOM;
      lfsr      <= `PSFC_LFSR_SEED;
      hs        <= '0;
    end else begin
      sw_cnt    <= next_sw_cnt;
      sw_period <= next_sw_period;
      lfsr      <= next_lfsr;
      hs        <= next_hs;
    end
  end

  assign hs_switch_out = hs;

  // watchdog: only runs once power good is released and seen high
  always_comb begin
    wd_run        = (state == ST_ACTIVE) && pg_release && power_good_in;
    next_kick_lvl = kick_done ? watchdog_kick_input_in : kick_lvl;
    kick          = wd_run && (kick_done || bus_kick_in);
    wd_fault      = 1'b0;
    next_wd_cnt   = '0;
    if (wd_run) begin
      next_wd_cnt = wd_cnt + `PSFC_CNT_W'(1);
      if (kick) begin
        // window mode also punishes a kick that comes too early
        wd_fault    = window_watchdog_mode_in && (wd_cnt < `PSFC_CNT_W'(WD_EARLY_CYC));
        next_wd_cnt = '0;
      end else if (wd_cnt == `PSFC_CNT_W'(WD_LATE_CYC - 1)) begin
        wd_fault    = 1'b1;
        next_wd_cnt = '0;
      end
    end
    if (wd_fault) begin
      next_err_cnt = `PSFC_CNT_W'(ERR_CYC);
    end else if (err_cnt != '0) begin
      next_err_cnt = err_cnt - `PSFC_CNT_W'(1);
    end else begin
      next_err_cnt = '0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      kick_lvl                    <= 1'b0;
      wd_cnt                      <= '0;
      err_cnt                     <= '0;
      watchdog_error_output_n_out <= 1'b1;
    end else begin
      kick_lvl                    <= next_kick_lvl;
      wd_cnt                      <= next_wd_cnt;
      err_cnt                     <= next_err_cnt;
      watchdog_error_output_n_out <= (next_err_cnt == '0);
    end
  end

  // checks on the behaviour above
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_hard_off;
    (reg_enable_out == 5'd0) && power_good_oe_out;
  endsequence

  property p_uv_off;
    uv_done |=> s_hard_off ##1 (lockout && reg_enable_out == 5'd0);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("lockout did not stop outputs");

  property p_ovp_off;
    supply_ov_in |=> s_hard_off and !fault_indicator_output_n_out;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("overvoltage did not shut down");

  property p_otw_run;
    (overtemp_warning_in && !shutdown && state == ST_ACTIVE && next_state == ST_ACTIVE)
      |=> !fault_indicator_output_n_out && $stable(reg_enable_out);
  endproperty
  a_otw_run: assert property (p_otw_run) else $error("warning handling wrong");

  property p_tsd_off;
    thermal_shutdown_in |=> s_hard_off and (state == ST_REG_OFF);
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("thermal shutdown ignored");

  property p_hs_start;
    sw_start[0] |=> hs_switch_out[0];
  endproperty
  a_hs_start: assert property (p_hs_start) else $error("high side missed cycle start");

  property p_hs_trip;
    (peak_trip_in[1] && !sw_start[1]) |=> !hs_switch_out[1];
  endproperty
  a_hs_trip: assert property (p_hs_trip) else $error("peak trip did not end on time");

  property p_dither;
    (sw_period <= SW_NOM) && (sw_period >= SW_NOM - {4'd0, SW_SPAN});
  endproperty
  a_dither: assert property (p_dither) else $error("switching period out of range");

  // a fault on an unfitted channel alone must leave the indicator high
  property p_mask;
    (!used[1] && ch_fault_in == 5'h02 && !overtemp_warning_in && !shutdown
      && next_state != ST_REG_OFF) |=> fault_indicator_output_n_out;
  endproperty
  a_mask: assert property (p_mask) else $error("unused channel fault leaked");

  property p_pg_delay;
    $fell(power_good_oe_out) |-> $past(state) == ST_PG_DELAY
      && $past(pg_cnt) == `PSFC_CNT_W'(PG_CYC - 1);
  endproperty
  a_pg_delay: assert property (p_pg_delay) else $error("power good released early");

  property p_err_pulse;
    $fell(watchdog_error_output_n_out) |-> !watchdog_error_output_n_out [*8]
      ##0 (err_cnt == `PSFC_CNT_W'(ERR_CYC - 7));
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("watchdog error pulse wrong");

  property p_wd_idle;
    !wd_run |=> (wd_cnt == '0);
  endproperty
  a_wd_idle: assert property (p_wd_idle) else $error("watchdog ran before power good");
endmodule

// ===== verification/psfc_mcu_model.sv
// microcontroller side model: reads the power good wire and kicks the watchdog
`timescale 1ns/1ps
module psfc_mcu_model (
  input  wire logic clk_in,
  input  wire logic pg_data_in,
  input  wire logic pg_oe_in,
  output logic      pg_wire_out,
  output logic      kick_pin_out,
  output logic      kick_bus_out
);
  // the pull-up gives the high level; the device may only pull low or let go
  assign pg_wire_out = pg_oe_in ? pg_data_in : 1'b1;
  // idle levels before any kick
  initial begin
    kick_pin_out = 1'b0;
    kick_bus_out = 1'b0;
  end
  // pin kick: one level change, then held for the given number of cycles
  task automatic kick_pin(input int hold);
    @(posedge clk_in);
    #1 kick_pin_out = ~kick_pin_out;
    repeat (hold) @(posedge clk_in);
    #1;
  endtask
  // bus kick: a single cycle pulse from the serial side
  task automatic kick_bus();
    @(posedge clk_in);
    #1 kick_bus_out = 1'b1;
    @(posedge clk_in);
    #1 kick_bus_out = 1'b0;
  endtask
endmodule

// ===== verification/tb.sv
// self-checking bench for the supervisor fault control block
`timescale 1ns/1ps
module tb;
  import psfc_pkg::*;
  localparam int UV    = 20;  // shortened lockout filter
  localparam int PG    = 50;  // shortened power good delay
  localparam int ERR   = 16;  // shortened error pulse
  localparam int KICK  = 8;   // shortened kick deglitch
  localparam int EARLY = 30;  // window early limit
  localparam int LATE  = 100; // late limit
  logic clk_in, rst_in, supply_low_in, supply_ok_in, supply_ov_in, supply_resume_in;
  logic overtemp_warning_in, thermal_shutdown_in, seq_enable_in, dither_enable_in;
  logic ch2_float_in, ch3_float_in, window_watchdog_mode_in;
  logic watchdog_kick_input_in, bus_kick_in, power_good_in, power_good_output_out;
  logic power_good_oe_out, fault_indicator_output_n_out, watchdog_error_output_n_out;
  logic [2:0] conv_enable_in, peak_trip_in, hs_switch_out;
  logic [4:0] ch_ready_in, ch_fault_in, reg_enable_out;
  psfc_state_e state_out;
  int bad_count, check_count, cycles, err_low;
  psfc_top #(.UV_CYC(UV), .PG_CYC(PG), .ERR_CYC(ERR), .KICK_CYC(KICK),
    .WD_EARLY_CYC(EARLY), .WD_LATE_CYC(LATE)) i_psfc_top (
    .clk_in, .rst_in, .supply_low_in, .supply_ok_in, .supply_ov_in, .supply_resume_in,
    .overtemp_warning_in, .thermal_shutdown_in, .seq_enable_in, .conv_enable_in,
    .dither_enable_in, .peak_trip_in, .ch_ready_in, .ch_fault_in, .ch2_float_in,
    .ch3_float_in, .window_watchdog_mode_in, .watchdog_kick_input_in, .bus_kick_in,
    .power_good_in, .reg_enable_out, .hs_switch_out, .power_good_output_out,
    .power_good_oe_out, .fault_indicator_output_n_out, .watchdog_error_output_n_out,
    .state_out);
  psfc_mcu_model i_psfc_mcu_model (.clk_in, .pg_data_in(power_good_output_out),
    .pg_oe_in(power_good_oe_out), .pg_wire_out(power_good_in),
    .kick_pin_out(watchdog_kick_input_in), .kick_bus_out(bus_kick_in));
  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // hang guard and error pulse length meter
  always @(posedge clk_in) begin
    cycles++;
    if (watchdog_error_output_n_out === 1'b0)
      err_low++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  // step n edges, then settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // one comparison, reported at once on mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for a state
  task automatic wait_state(input psfc_state_e s, output int n);
    n = 0;
    while (state_out !== s && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  // power on and walk to active; power good must wait out its delay
  task automatic power_up(input logic [4:0] exp_en);
    int n;
    seq_enable_in = 1'b1;
    wait_state(ST_PG_DELAY, n);
    chk(reg_enable_out, exp_en);
    chk(power_good_oe_out, 1'b1);
    wait_state(ST_ACTIVE, n);
    chk(n >= PG - 1 && n <= PG + 1, 1'b1);
    chk(power_good_in, 1'b1);
  endtask
  // short dip ignored, long dip shuts down, recovery restarts from defaults
  task automatic t_lockout();
    supply_low_in = 1'b1;
    cyc(UV);
    supply_low_in = 1'b0;
    cyc(2);
    chk(reg_enable_out, 5'h1F);
    supply_low_in = 1'b1;
    supply_ok_in = 1'b0;
    cyc(UV + 3);
    chk(reg_enable_out, 5'h00);
    supply_low_in = 1'b0;
    cyc(5);
    chk(state_out, ST_REG_OFF);
    supply_ok_in = 1'b1;
    power_up(5'h1F);
  endtask
  // overvoltage trip, interrupted resume filter, then automatic restart
  task automatic t_ovp();
    supply_ov_in = 1'b1;
    cyc(2);
    chk(reg_enable_out, 5'h00);
    chk(power_good_oe_out, 1'b1);
    chk(fault_indicator_output_n_out, 1'b0);
    supply_ov_in = 1'b0;
    supply_resume_in = 1'b1;
    cyc(500);
    supply_resume_in = 1'b0;
    cyc(2);
    supply_resume_in = 1'b1;
    cyc(990);
    chk(state_out, ST_REG_OFF);
    cyc(12);
    chk(state_out !== ST_REG_OFF, 1'b1);
    supply_resume_in = 1'b0;
    power_up(5'h1F);
  endtask
  // warning keeps outputs up, shutdown drops them, comparator release restarts
  task automatic t_thermal();
    overtemp_warning_in = 1'b1;
    cyc(3);
    chk(fault_indicator_output_n_out, 1'b0);
    chk(reg_enable_out, 5'h1F);
    overtemp_warning_in = 1'b0;
    thermal_shutdown_in = 1'b1;
    cyc(3);
    chk(reg_enable_out, 5'h00);
    chk(power_good_oe_out, 1'b1);
    chk(state_out, ST_REG_OFF);
    thermal_shutdown_in = 1'b0;
    cyc(3);
    chk(state_out !== ST_REG_OFF, 1'b1);
    power_up(5'h1F);
  endtask
  // floating second channel is left off and its faults are masked
  task automatic t_float();
    seq_enable_in = 1'b0;
    ch2_float_in = 1'b1;
    ch_ready_in = 5'h1D;
    cyc(3);
    power_up(5'h1D);
    ch_fault_in = 5'h02;
    cyc(3);
    chk(fault_indicator_output_n_out, 1'b1);
    ch_fault_in = 5'h04;
    cyc(3);
    chk(fault_indicator_output_n_out, 1'b0);
    ch_fault_in = 5'h00;
    ch2_float_in = 1'b0;
    ch_ready_in = 5'h1F;
  endtask
  // switching periods, on-times and second converter offset over a window
  task automatic gaps(output int lo, hi, off, ons, n);
    int t0;
    logic [2:0] prev;
    lo = 999;
    hi = 0;
    off = -1;
    ons = 0;
    n = 0;
    t0 = -1;
    prev = hs_switch_out;
    for (int i = 0; i < 1000; i++) begin
      cyc(1);
      ons += hs_switch_out[0];
      if (hs_switch_out[1] && !prev[1] && t0 >= 0 && off < 0)
        off = i - t0;
      if (hs_switch_out[0] && !prev[0]) begin
        if (t0 >= 0 && i - t0 < lo)
          lo = i - t0;
        if (t0 >= 0 && i - t0 > hi)
          hi = i - t0;
        t0 = i;
        n++;
      end
      prev = hs_switch_out;
    end
  endtask
  // two then three converters: fixed period, half and third period offsets, dither, peak trip
  task automatic t_switch();
    int lo, hi, off, ons, n;
    seq_enable_in = 1'b0;
    conv_enable_in = 3'b011;
    cyc(3);
    power_up(5'h1B);
    gaps(lo, hi, off, ons, n);
    chk(lo == 95 && hi == 95, 1'b1);
    chk(off == 47 || off == 48, 1'b1);
    chk(ons == n && n > 8, 1'b1);
    dither_enable_in = 1'b1;
    gaps(lo, hi, off, ons, n);
    chk(lo >= 90 && hi <= 95 && lo < 95, 1'b1);
    dither_enable_in = 1'b0;
    peak_trip_in = 3'b000;
    cyc(100);
    chk(hs_switch_out[1:0], 2'b11);
    peak_trip_in = 3'b111;
    conv_enable_in = 3'b111;
    gaps(lo, hi, off, ons, n);
    chk(off == 31 || off == 32, 1'b1);
  endtask
  // watchdog: early kick in window mode, pin kicks, simple mode timeout
  task automatic t_watchdog();
    seq_enable_in = 1'b0;
    cyc(3);
    power_up(5'h1F);
    window_watchdog_mode_in = 1'b1;
    err_low = 0;
    i_psfc_mcu_model.kick_bus();
    cyc(1);
    chk(watchdog_error_output_n_out, 1'b0);
    cyc(ERR + 10);
    chk(err_low, ERR);
    chk(watchdog_error_output_n_out, 1'b1);
    err_low = 0;
    repeat (5) i_psfc_mcu_model.kick_pin(45);
    chk(err_low, 0);
    window_watchdog_mode_in = 1'b0;
    i_psfc_mcu_model.kick_bus();
    i_psfc_mcu_model.kick_pin(4);
    i_psfc_mcu_model.kick_pin(4);
    cyc(LATE - 20);
    chk(err_low, 0);
    cyc(40);
    chk(err_low != 0, 1'b1);
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end
    else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {supply_low_in, supply_ov_in, supply_resume_in, overtemp_warning_in} = 4'h0;
    {thermal_shutdown_in, seq_enable_in, dither_enable_in, ch2_float_in} = 4'h0;
    {ch3_float_in, window_watchdog_mode_in} = 2'b00;
    supply_ok_in = 1'b1;
    conv_enable_in = 3'b111;
    peak_trip_in = 3'b111;
    ch_ready_in = 5'h1F;
    ch_fault_in = 5'h00;
    rst_in = 1'b1;
    cyc(3);
    rst_in = 1'b0;
    power_up(5'h1F);
    t_lockout();
    t_ovp();
    t_thermal();
    t_float();
    t_switch();
    t_watchdog();
    close_out();
  end
endmodule
